/* core/rocr_pkg.sv */
package rocr_pkg;

	// ----------------------------------------------------------------
	// bus geometry
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_OSC_CTRL  = 8'h00;
	localparam logic [7:0] OFF_DRIVE_LO  = 8'h04;
	localparam logic [7:0] OFF_DRIVE_HI  = 8'h08;
	localparam logic [7:0] OFF_STATUS    = 8'h18;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int unsigned CODE_W        = 12;
	localparam int unsigned EN_LSB        = 12;
	localparam int unsigned RANGE_LSB     = 0;
	localparam int unsigned KEY_LSB       = 16;
	localparam int unsigned KEY_W         = 16;
	localparam int unsigned BAD_BIT       = 24;
	localparam int unsigned ON_BIT        = 12;
	localparam int unsigned NSTAGE        = 8;
	localparam int unsigned DRV_W         = 3;
	localparam int unsigned DRV_PITCH     = 4;
	localparam int unsigned STG_PER_REG   = 4;
	localparam int unsigned LVL_W         = 2;

	// ----------------------------------------------------------------
	// codes and reset values
	// ----------------------------------------------------------------
	localparam logic [11:0] EN_CODE_STOP   = 12'hd1e;
	localparam logic [11:0] EN_CODE_RUN    = 12'hfab;
	localparam logic [11:0] RANGE_RST      = 12'haa0;
	localparam logic [11:0] RANGE_LOW      = 12'hfa4;
	localparam logic [11:0] RANGE_MEDIUM   = 12'hfa5;
	localparam logic [11:0] RANGE_HIGH     = 12'hfa7;
	localparam logic [11:0] RANGE_OVERSPD  = 12'hfa6;
	localparam logic [15:0] WRITE_KEY      = 16'h9696;
	localparam logic [15:0] KEY_RST        = 16'h0000;
	localparam logic [11:0] DRV_RST        = 12'h000;

	// stages in the loop per range
	localparam logic [7:0] MASK_LOW      = 8'hff;
	localparam logic [7:0] MASK_MEDIUM   = 8'hfc;
	localparam logic [7:0] MASK_HIGH     = 8'hf0;
	localparam logic [7:0] MASK_OVERSPD  = 8'hc0;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		RNG_LOW     = 4'b0001,
		RNG_MEDIUM  = 4'b0010,
		RNG_HIGH    = 4'b0100,
		RNG_OVERSPD = 4'b1000
	} rocr_range_e;

	typedef struct packed {
		logic [11:0]  en_code;
		logic [11:0]  range_code;
		logic         osc_on;
		rocr_range_e  range;
		logic [7:0]   loop_mask;
		logic [15:0]  key_lo;
		logic [11:0]  drv_lo;
		logic [15:0]  key_hi;
		logic [11:0]  drv_hi;
		logic         bad;
		logic [31:0]  rdata;
	} rocr_regs_s;

endpackage : rocr_pkg

/* core/rocr_drive_level.sv */
`timescale 1ns/1ps

module rocr_drive_level #(
	parameter int unsigned NSTG = 8,
	parameter int unsigned DW   = 3,
	parameter int unsigned LW   = 2
) (
	input  wire logic                 mclk,
	input  wire logic                 rstn,
	input  wire logic [NSTG*DW-1:0]   drive,
	output logic      [NSTG*LW-1:0]   level
);
	import rocr_pkg::*;

	// ----------------------------------------------------------------
	// parameter check
	// ----------------------------------------------------------------
	if (DW != 3 || LW != 2 || NSTG == 0) begin : g_chk
		$error("rocr_drive_level: level needs three drive bits per stage");
	end

	typedef struct packed {
		logic [NSTG*LW-1:0] lvl;
	} rocr_lvl_s;

	rocr_lvl_s st_q;
	rocr_lvl_s st_d;

	// count of set drive bits gives base, double, triple, quadruple
	function automatic logic [1:0] rocr_ones(input logic [2:0] b);
		logic [1:0] n;
		n = {1'b0, b[0]} + {1'b0, b[1]} + {1'b0, b[2]};
		return n;
	endfunction : rocr_ones

	// per-stage level
	always_comb begin
		st_d = st_q;
		for (int i = 0; i < NSTG; i++) begin
			st_d.lvl[i*LW +: LW] = rocr_ones(drive[i*DW +: DW]);
		end
	end

	// state register
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign level = st_q.lvl;

endmodule : rocr_drive_level

/* core/rocr_regs.sv */
`timescale 1ns/1ps

// Behaviour
// - on/off code sits in control 23:12, loads run code at reset.
// - only code d1e stops oscillator; fab or any other value runs it.
// - range selector in control 11:0, resets to aa0, picks ring length.
// - range codes fa4 low, fa5 medium, fa7 high.
// - low uses stages 0-7, medium 2-7, high 4-7.
// - stage strength is count of its three set drive bits.
// - drive settings applied only when key 31:16 equals 9696.
// - wrong key forces all stage drives in that register to zero.
// - first drive register holds stages 0-3 at 2:0,6:4,10:8,14:12.
// - second drive register holds stages 4-7 in same layout.
// - reset clears all drive fields and both keys.
// - invalid code or key sets sticky flag bit 24, cleared by writing one to it.
// - reset range behaves as low, all eight stages in loop.
module rocr_regs (
	input  wire logic                          mclk,
	input  wire logic                          rstn,
	input  wire logic [rocr_pkg::ADDR_W-1:0]   addr,
	input  wire logic [rocr_pkg::DATA_W-1:0]   wdata,
	input  wire logic                          wr_en,
	input  wire logic                          rd_en,
	output logic      [rocr_pkg::DATA_W-1:0]   rdata,
	output logic                               osc_enable,
	output logic      [3:0]                    loop_range,
	output logic      [rocr_pkg::NSTAGE-1:0]   loop_stages,
	output logic      [rocr_pkg::NSTAGE*3-1:0] stage_drive,
	output logic      [rocr_pkg::NSTAGE*2-1:0] stage_level,
	output logic                               invalid_write_flag
);
	import rocr_pkg::*;

	// ----------------------------------------------------------------
	// elaboration checks on the shared constants
	// ----------------------------------------------------------------
	// two drive registers of four stages each must cover the whole ring
	if (NSTAGE != 2 * STG_PER_REG) begin : g_chk_stages
		$error("rocr_regs: stage count must fill both drive registers");
	end
	// a stage field must fit its slot and the key must fit the word
	if (DRV_W > DRV_PITCH || KEY_LSB + KEY_W > DATA_W) begin : g_chk_fields
		$error("rocr_regs: drive fields or key overrun their slots");
	end
	// range code sits below the on/off code, which sits below the flag
	if (RANGE_LSB + CODE_W > EN_LSB || EN_LSB + CODE_W > BAD_BIT) begin : g_chk_codes
		$error("rocr_regs: control codes overlap");
	end
	// the status mirror and the flag need bits of their own
	if (ON_BIT == BAD_BIT || BAD_BIT >= DATA_W) begin : g_chk_status
		$error("rocr_regs: status bits collide");
	end
	// ports and offsets are sized for eight stages of three bits
	if (NSTAGE != 8 || DRV_W != 3 || LVL_W != 2 || ADDR_W != 8) begin : g_chk_ports
		$error("rocr_regs: port widths do not match the constants");
	end
	// medium and high must only drop stages from the next slower range
	if (|(MASK_MEDIUM & ~MASK_LOW) || |(MASK_HIGH & ~MASK_MEDIUM)) begin : g_chk_mask
		$error("rocr_regs: range masks are not nested");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	rocr_regs_s st_q;
	rocr_regs_s st_d;

	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------

	// gather four 3-bit stage fields out of their 4-bit slots
	function automatic logic [11:0] rocr_pack(input logic [31:0] w);
		logic [11:0] p;
		p = '0;
		for (int i = 0; i < STG_PER_REG; i++) begin
			p[i*DRV_W +: DRV_W] = w[i*DRV_PITCH +: DRV_W];
		end
		return p;
	endfunction : rocr_pack

	// place packed stage fields back, reserved bits zero
	function automatic logic [31:0] rocr_unpack(
		input logic [15:0] key,
		input logic [11:0] drv
	);
		logic [31:0] w;
		w = ZERO_WORD;
		for (int i = 0; i < STG_PER_REG; i++) begin
			w[i*DRV_PITCH +: DRV_W] = drv[i*DRV_W +: DRV_W];
		end
		w[KEY_LSB +: KEY_W] = key;
		return w;
	endfunction : rocr_unpack

	// a drive write is honoured only with the matching key
	function automatic logic [11:0] rocr_keyed(input logic [31:0] w);
		logic [11:0] d;
		if (w[KEY_LSB +: KEY_W] == WRITE_KEY) begin
			d = rocr_pack(w);
		end else begin
			d = DRV_RST;
		end
		return d;
	endfunction : rocr_keyed

	// codes are gray coded, which is why overspeed follows high
	// range code to one-hot range; unknown codes fall to low
	function automatic rocr_range_e rocr_range(input logic [11:0] c);
		rocr_range_e r;
		unique case (c)
			RANGE_LOW:     r = RNG_LOW;
			RANGE_MEDIUM:  r = RNG_MEDIUM;
			RANGE_HIGH:    r = RNG_HIGH;
			RANGE_OVERSPD: r = RNG_OVERSPD;
			default:       r = RNG_LOW;
		endcase
		return r;
	endfunction : rocr_range

	// stages that form the ring for a range
	function automatic logic [7:0] rocr_mask(input rocr_range_e r);
		logic [7:0] m;
		unique case (r)
			RNG_LOW:     m = MASK_LOW;
			RNG_MEDIUM:  m = MASK_MEDIUM;
			RNG_HIGH:    m = MASK_HIGH;
			RNG_OVERSPD: m = MASK_OVERSPD;
			default:     m = MASK_LOW;
		endcase
		return m;
	endfunction : rocr_mask

	// true for any of the four documented range codes
	function automatic logic rocr_range_ok(input logic [11:0] c);
		return (c == RANGE_LOW) || (c == RANGE_MEDIUM) ||
		       (c == RANGE_HIGH) || (c == RANGE_OVERSPD);
	endfunction : rocr_range_ok

	// true for the two named on/off codes; anything else is a stray write
	function automatic logic rocr_en_ok(input logic [11:0] c);
		return (c == EN_CODE_STOP) || (c == EN_CODE_RUN);
	endfunction : rocr_en_ok

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic        wr_ctrl;
	logic        wr_lo;
	logic        wr_hi;
	logic        wr_stat;
	logic [11:0] w_en;
	logic [11:0] w_rng;
	logic [15:0] w_key;
	logic        bad_set;
	logic        bad_clr;

	// exact address match; unmapped offsets fall through as no-ops
	// write strobes per register and written fields
	always_comb begin
		wr_ctrl = wr_en && (addr == OFF_OSC_CTRL);
		wr_lo   = wr_en && (addr == OFF_DRIVE_LO);
		wr_hi   = wr_en && (addr == OFF_DRIVE_HI);
		wr_stat = wr_en && (addr == OFF_STATUS);
		w_en    = wdata[EN_LSB +: CODE_W];
		w_rng   = wdata[RANGE_LSB +: CODE_W];
		w_key   = wdata[KEY_LSB +: KEY_W];
	end

	// invalid value detection on any guarded write
	always_comb begin
		bad_set = 1'b0;
		if (wr_ctrl) begin
			if (!rocr_en_ok(w_en)) begin
				bad_set = 1'b1;
			end
			if (!rocr_range_ok(w_rng)) begin
				bad_set = 1'b1;
			end
		end
		if ((wr_lo || wr_hi) && (w_key != WRITE_KEY)) begin
			bad_set = 1'b1;
		end
		bad_clr = wr_stat && wdata[BAD_BIT];
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;

		// a stop code is obeyed even while the ring clocks the system;
		// software has to move the system clock away before writing it
		// control: whole word taken at once
		if (wr_ctrl) begin
			st_d.en_code    = w_en;
			st_d.osc_on     = (w_en != EN_CODE_STOP);
			st_d.range_code = w_rng;
			st_d.range      = rocr_range(w_rng);
			st_d.loop_mask  = rocr_mask(rocr_range(w_rng));
		end

		// a wrong key still lands in the key field, so software sees it
		// drive registers, keyed
		if (wr_lo) begin
			st_d.key_lo = w_key;
			st_d.drv_lo = rocr_keyed(wdata);
		end
		if (wr_hi) begin
			st_d.key_hi = w_key;
			st_d.drv_hi = rocr_keyed(wdata);
		end

		// event and clear cannot share a cycle here, set wins regardless
		// sticky flag: a new event beats a clear
		if (bad_set) begin
			st_d.bad = 1'b1;
		end else if (bad_clr) begin
			st_d.bad = 1'b0;
		end

		// read data valid only the cycle after the strobe
		st_d.rdata = ZERO_WORD;
		if (rd_en) begin
			unique case (addr)
				OFF_OSC_CTRL: begin
					st_d.rdata[EN_LSB +: CODE_W]    = st_q.en_code;
					st_d.rdata[RANGE_LSB +: CODE_W] = st_q.range_code;
				end
				OFF_DRIVE_LO: begin
					st_d.rdata = rocr_unpack(st_q.key_lo, st_q.drv_lo);
				end
				OFF_DRIVE_HI: begin
					st_d.rdata = rocr_unpack(st_q.key_hi, st_q.drv_hi);
				end
				// status: sticky flag plus a mirror of the run level
				OFF_STATUS: begin
					st_d.rdata[BAD_BIT] = st_q.bad;
					st_d.rdata[ON_BIT]  = st_q.osc_on;
				end
				default: begin
					st_d.rdata = ZERO_WORD; // unmapped reads zero
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// reset loads the run code so the ring starts at power-up
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st_q.en_code    <= EN_CODE_RUN;
			st_q.osc_on     <= 1'b1;
			st_q.range_code <= RANGE_RST;
			st_q.range      <= RNG_LOW;
			st_q.loop_mask  <= MASK_LOW;
			st_q.key_lo     <= KEY_RST;
			st_q.drv_lo     <= DRV_RST;
			st_q.key_hi     <= KEY_RST;
			st_q.drv_hi     <= DRV_RST;
			st_q.bad        <= 1'b0;
			st_q.rdata      <= ZERO_WORD;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// drive strength levels
	// ----------------------------------------------------------------
	// levels follow the raw drive bits one cycle later
	rocr_drive_level #(
		.NSTG (NSTAGE),
		.DW   (DRV_W),
		.LW   (LVL_W)
	) u_level (
		.mclk  (mclk),
		.rstn  (rstn),
		.drive ({st_q.drv_hi, st_q.drv_lo}),
		.level (stage_level)
	);

	// ----------------------------------------------------------------
	// outputs, all from flops
	// ----------------------------------------------------------------
	// every output is a register bit, no logic after the flops
	assign rdata              = st_q.rdata;
	assign osc_enable         = st_q.osc_on;
	assign loop_range         = st_q.range;
	assign loop_stages        = st_q.loop_mask;
	assign stage_drive        = {st_q.drv_hi, st_q.drv_lo};
	assign invalid_write_flag = st_q.bad;

endmodule : rocr_regs

/* bench/rocr_regs_checker.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// port watcher for the ring oscillator register block
// ----------------------------------------------------------------
module rocr_checker (
	input wire logic        mclk,
	input wire logic        rstn,
	input wire logic [7:0]  addr,
	input wire logic [31:0] wdata,
	input wire logic        wr_en,
	input wire logic        rd_en,
	input wire logic [31:0] rdata,
	input wire logic        osc_enable,
	input wire logic [3:0]  loop_range,
	input wire logic [7:0]  loop_stages,
	input wire logic [23:0] stage_drive,
	input wire logic [15:0] stage_level,
	input wire logic        invalid_write_flag
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);

	// control register write
	sequence ctrl_wr;
		wr_en && addr == 8'h00;
	endsequence

	stop_code_a: assert property (ctrl_wr ##0 wdata[23:12] == 12'hd1e |=> !osc_enable)
		else $error("stop code left oscillator on");
	run_code_a: assert property (ctrl_wr ##0 wdata[23:12] != 12'hd1e |=> osc_enable)
		else $error("non-stop code left oscillator off");
	mid_range_a: assert property (ctrl_wr ##0 wdata[11:0] == 12'hfa5
		|=> loop_range == 4'b0010 && loop_stages == 8'hfc) else $error("medium range wrong");
	high_range_a: assert property (ctrl_wr ##0 wdata[11:0] == 12'hfa7
		|=> loop_range == 4'b0100 && loop_stages == 8'hf0) else $error("high range wrong");
	bad_range_a: assert property (ctrl_wr ##0 !(wdata[11:0] inside {[12'hfa4:12'hfa7]})
		|=> loop_range == 4'b0001 && loop_stages == 8'hff && invalid_write_flag)
		else $error("unknown range not low with flag");
	bad_key_a: assert property (wr_en && addr == 8'h04 && wdata[31:16] != 16'h9696
		|=> stage_drive[11:0] == 12'h000 && invalid_write_flag) else $error("bad key kept drive");
	key_apply_a: assert property (wr_en && addr == 8'h08 && wdata[31:16] == 16'h9696
		|=> stage_drive[23:12] == {$past(wdata[14:12]), $past(wdata[10:8]),
		$past(wdata[6:4]), $past(wdata[2:0])}) else $error("keyed drive not applied");
	stage_level_a: assert property (stage_level[1:0] == 2'($countones($past(stage_drive[2:0]))))
		else $error("stage 0 level not bit count");
	resv_zero_a: assert property (rd_en && addr == 8'h04
		|=> {rdata[15], rdata[11], rdata[7], rdata[3]} == 4'h0) else $error("reserved bit read one");
	flag_hold_a: assert property (invalid_write_flag && !(wr_en && addr == 8'h18)
		|=> invalid_write_flag) else $error("sticky flag dropped");
endmodule : rocr_checker

bind rocr_regs rocr_checker chk_u (.mclk, .rstn, .addr, .wdata, .wr_en, .rd_en, .rdata,
	.osc_enable, .loop_range, .loop_stages, .stage_drive, .stage_level, .invalid_write_flag);

/* bench/ring_osc_control_regs_test.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// self-checking bench for the ring oscillator register block
// ----------------------------------------------------------------
module ring_osc_control_regs_test;
	logic        mclk  = 1'b0;
	logic        rstn  = 1'b0;
	logic [7:0]  addr  = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr_en = 1'b0;
	logic        rd_en = 1'b0;
	logic [31:0] rdata;
	logic        osc_enable;
	logic [3:0]  loop_range;
	logic [7:0]  loop_stages;
	logic [23:0] stage_drive;
	logic [15:0] stage_level;
	logic        invalid_write_flag;
	int          err_total = 0;
	int          tests_run = 0;

	// 100 MHz clock
	always #5 mclk = ~mclk;

	rocr_regs dut_u (.mclk, .rstn, .addr, .wdata, .wr_en, .rd_en, .rdata, .osc_enable,
		.loop_range, .loop_stages, .stage_drive, .stage_level, .invalid_write_flag);

	// compare and count
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// one-cycle write, returns just after the edge that took it
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
		#1;
	endtask : wr

	// one-cycle read, data judged in the following cycle
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1;
		chk("rdata", e, rdata);
	endtask : rd

	task end_of_test;
		$display("tests_run %0d err_total %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test

	task t_reset;
		chk("osc_enable", 1, osc_enable);
		chk("loop_range", 4'b0001, loop_range);
		chk("loop_stages", 8'hff, loop_stages);
		chk("stage_drive", 0, stage_drive);
		chk("stage_level", 0, stage_level);
		chk("flag", 0, invalid_write_flag);
		rd(8'h00, 32'h00fabaa0);
		rd(8'h04, 0);
		rd(8'h08, 0);
		rd(8'h18, 32'h00001000);
		$display("reset test done");
	endtask : t_reset

	// one range write, judged on the outputs and on read-back
	task range_step(input logic [11:0] c, input logic [3:0] r, input logic [7:0] m);
		wr(8'h00, {8'h00, 12'hfab, c});
		chk("loop_range", r, loop_range);
		chk("loop_stages", m, loop_stages);
		rd(8'h00, {8'h00, 12'hfab, c});
	endtask : range_step

	task t_range;
		// step up one range at a time; overspeed is kept off a running ring
		range_step(12'hfa4, 4'b0001, 8'hff);
		range_step(12'hfa5, 4'b0010, 8'hfc);
		range_step(12'hfa7, 4'b0100, 8'hf0);
		chk("flag", 0, invalid_write_flag);
		// dropping to low may glitch the ring; the bench clock is its own
		wr(8'h00, 32'h00fab123);
		chk("loop_range", 4'b0001, loop_range);
		chk("loop_stages", 8'hff, loop_stages);
		chk("flag", 1, invalid_write_flag);
		wr(8'h18, 32'h0);
		chk("flag", 1, invalid_write_flag);
		wr(8'h18, 32'h01000000);
		chk("flag", 0, invalid_write_flag);
		$display("range test done");
	endtask : t_range

	task t_enable;
		// the bench clock never comes from the ring, so stopping it is safe
		wr(8'h00, 32'h00d1efa4);
		chk("osc_enable", 0, osc_enable);
		rd(8'h18, 32'h0);
		// overspeed only probed while the ring stands still
		wr(8'h00, 32'h00d1efa6);
		chk("loop_range", 4'b1000, loop_range);
		chk("loop_stages", 8'hc0, loop_stages);
		chk("osc_enable", 0, osc_enable);
		chk("flag", 0, invalid_write_flag);
		// back down to low in the same write that restarts the ring
		wr(8'h00, 32'h00fabfa4);
		chk("osc_enable", 1, osc_enable);
		chk("loop_range", 4'b0001, loop_range);
		wr(8'h00, 32'h00555fa4);
		chk("osc_enable", 1, osc_enable);
		rd(8'h18, 32'h01001000);
		wr(8'h18, 32'h01000000);
		$display("enable test done");
	endtask : t_enable

	task t_drive;
		wr(8'h04, 32'h9696ffff);
		chk("drive_lo", 12'hfff, stage_drive[11:0]);
		@(posedge mclk);
		#1;
		chk("level_lo", 8'hff, stage_level[7:0]);
		rd(8'h04, 32'h96967777);
		wr(8'h08, 32'h96961234);
		chk("drive_hi", {3'd1, 3'd2, 3'd3, 3'd4}, stage_drive[23:12]);
		@(posedge mclk);
		#1;
		chk("level_hi", 8'h59, stage_level[15:8]);
		chk("flag", 0, invalid_write_flag);
		wr(8'h08, 32'h12341234);
		chk("drive_hi", 0, stage_drive[23:12]);
		chk("drive_lo", 12'hfff, stage_drive[11:0]);
		chk("flag", 1, invalid_write_flag);
		rd(8'h08, 32'h12340000);
		// wrong key on the low register wipes stages 0 to 3
		wr(8'h04, 32'h0000ffff);
		chk("drive_lo", 0, stage_drive[11:0]);
		@(posedge mclk);
		#1;
		chk("level_lo", 0, stage_level[7:0]);
		rd(8'h04, 32'h0);
		$display("drive test done");
	endtask : t_drive

	task t_unmapped;
		wr(8'h40, 32'hffffffff);
		rd(8'h40, 0);
		rd(8'h00, 32'h00555fa4);
		wr(8'h18, 32'hffffffff);
		rd(8'h18, 32'h00001000);
		$display("unmapped test done");
	endtask : t_unmapped

	// main sequence
	initial begin
		repeat (8) @(posedge mclk);
		rstn <= 1'b1;
		t_reset;
		t_range;
		t_enable;
		t_drive;
		t_unmapped;
		end_of_test;
	end

	// hang guard counts as a mismatch
	initial begin
		#100000;
		err_total++;
		end_of_test;
	end
endmodule : ring_osc_control_regs_test
